//--- logic/rss_top.sv
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "rss_consts.svh"

// What this block does
// - Hold I/O reset, then load reset vector.
// - I/O reset set asynchronously by power-on or pin source.
// - Stretch reset by fuse-selected time-out after release.
// - Four sources: power-on, pin, watchdog, brown-out.
// - Watchdog expiry resets only while enabled.
// - Power-on detector reasserts reset immediately.
// - Low reset pin sets I/O reset even without clock.
// - Pin release waits full time-out.
// - Brown-out acts only with enable fuse.
// - Level fuse selects brown-out trigger level.
// - Brown-out dips shorter than minimum ignored.
// - Brown-out clear waits full time-out.
// - Watchdog reset pulse one clock long.
// - Watchdog flag set; cleared by power-on, write.
// - Brown-out flag set; cleared by power-on, write.
// - Pin flag set; cleared by power-on, write.
// - Power-on flag set; cleared only by software write or aresetn.
// - Bit 5 sleep select; others unused, zero.

module rss_top #(
  parameter int TOUT_BASE = `RSS_TOUT_BASE_CYC,
  parameter int BOD_MIN_CYC = `RSS_BOD_MIN_CYC,
  parameter logic [15:0] RESET_VECTOR = `RSS_RESET_VECTOR
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_detect,
  input wire logic ext_reset_n,
  input wire logic wdt_expire,
  input wire logic wdt_enable,
  input wire logic brownout_below,
  input wire logic brownout_enable_fuse,
  input wire logic brownout_level_fuse,
  input wire logic [1:0] clock_select_fuse,
  output logic cpu_reset_q,
  output logic io_reset_q,
  output logic vector_load_q,
  output logic [15:0] reset_vector_q,
  output logic bod_level_high_q,
  output logic sleep_select_top_bit_q,
  input wire logic [`RSS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`RSS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import rss_pkg::*;

  rss_state_t state_q;
  rss_state_t state_d;
  rss_src_t src;
  logic wdt_pulse_q;
  logic bod_trip;
  logic any_src;
  logic async_src;
  logic stretch_done;
  logic cpu_reset_d;
  logic [`RSS_CAUSE_W-1:0] cause_q;
  logic [`RSS_ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic aw_held_q;
  logic w_held_q;
  logic do_write;
  logic wr_hit;
  logic wr_clr_por;
  logic wdt_seen_q;
  logic aw_held_d;
  logic w_held_d;
  logic bvalid_d;
  logic rvalid_d;

  initial begin
    if (TOUT_BASE < 8 || BOD_MIN_CYC < 1) begin
      $error("Time-out or brown-out count too small.");
    end
  end

  function automatic logic reg_hit(input logic [`RSS_ADDR_W-1:0] a);
    reg_hit = (a == `RSS_CAUSE_OFF);
  endfunction : reg_hit

  // ----------------------------------------------------------------------
  // Reset sources.
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_pulse_q <= 1'b0;
      wdt_seen_q <= 1'b0;
    end else begin
      wdt_seen_q <= wdt_expire & wdt_enable;
      wdt_pulse_q <= wdt_expire & wdt_enable & ~wdt_seen_q;
    end
  end

  rss_bod_filter #(
    .MIN_CYC(BOD_MIN_CYC),
    .CNT_W(12)
  ) u_bod_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(brownout_enable_fuse),
    .below(brownout_below),
    .trip_q(bod_trip)
  );

  always_comb begin
    src.por = por_detect;
    src.pin = ~ext_reset_n;
    src.wdt = wdt_pulse_q;
    src.bod = bod_trip;
  end

  assign any_src = |src;
  assign async_src = por_detect | ~ext_reset_n;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bod_level_high_q <= 1'b0;
    end else begin
      bod_level_high_q <= brownout_level_fuse;
    end
  end

  // ----------------------------------------------------------------------
  // Stretch counter and sequencer.
  // ----------------------------------------------------------------------
  rss_stretch #(
    .TOUT_BASE(TOUT_BASE),
    .CNT_W(24)
  ) u_stretch (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(any_src),
    .sel(clock_select_fuse),
    .done_q(stretch_done)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      RSS_ST_HOLD: begin
        if (!any_src) begin
          state_d = RSS_ST_STRETCH;
        end
      end
      RSS_ST_STRETCH: begin
        if (any_src) begin
          state_d = RSS_ST_HOLD;
        end else if (stretch_done) begin
          state_d = RSS_ST_RUN;
        end
      end
      RSS_ST_RUN: begin
        if (any_src) begin
          state_d = RSS_ST_HOLD;
        end
      end
      default: begin
        state_d = RSS_ST_HOLD;
      end
    endcase
  end

  assign cpu_reset_d = (state_d != RSS_ST_RUN);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= RSS_ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_reset_q <= 1'b1;
      vector_load_q <= 1'b0;
      reset_vector_q <= RESET_VECTOR;
    end else begin
      cpu_reset_q <= cpu_reset_d;
      vector_load_q <= cpu_reset_q & ~cpu_reset_d;
      reset_vector_q <= RESET_VECTOR;
    end
  end

  // ----------------------------------------------------------------------
  // I/O port reset, set at once by the power-on and pin sources.
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk or posedge async_src) begin
    if (async_src) begin
      io_reset_q <= 1'b1;
    end else if (!aresetn) begin
      io_reset_q <= 1'b1;
    end else begin
      io_reset_q <= cpu_reset_d;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite write path.
  // ----------------------------------------------------------------------
  assign aw_held_d = (s_axi_awvalid & s_axi_awready) |
    (aw_held_q & ~do_write);
  assign w_held_d = (s_axi_wvalid & s_axi_wready) |
    (w_held_q & ~do_write);
  assign bvalid_d = do_write | (s_axi_bvalid & ~s_axi_bready);
  assign rvalid_d = (s_axi_arvalid & s_axi_arready) |
    (s_axi_rvalid & ~s_axi_rready);
  assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign wr_hit = do_write & reg_hit(awaddr_q) & wstrb0_q;
  assign wr_clr_por = wr_hit & ~wdata_q[`RSS_POR_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata[7:0];
      wstrb0_q <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RSS_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= reg_hit(awaddr_q) ? `RSS_RESP_OKAY : `RSS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite ready signals and read path.
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_awready <= ~aw_held_d & ~bvalid_d;
      s_axi_wready <= ~w_held_d & ~bvalid_d;
      s_axi_arready <= ~rvalid_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RSS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (reg_hit(s_axi_araddr)) begin
        s_axi_rdata <= {24'h000000, cause_q & `RSS_READ_MASK};
        s_axi_rresp <= `RSS_RESP_OKAY;
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= `RSS_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Reset cause register; a setting event wins over a clearing write.
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_q <= `RSS_CAUSE_RST;
    end else begin
      if (src.por) begin
        cause_q[`RSS_POR_BIT] <= 1'b1;
      end else if (wr_clr_por) begin
        cause_q[`RSS_POR_BIT] <= 1'b0;
      end
      if (src.por) begin
        cause_q[`RSS_WDT_BIT] <= 1'b0;
        cause_q[`RSS_BOD_BIT] <= 1'b0;
        cause_q[`RSS_PIN_BIT] <= 1'b0;
      end else begin
        if (src.wdt) begin
          cause_q[`RSS_WDT_BIT] <= 1'b1;
        end else if (wr_hit && !wdata_q[`RSS_WDT_BIT]) begin
          cause_q[`RSS_WDT_BIT] <= 1'b0;
        end
        if (src.bod) begin
          cause_q[`RSS_BOD_BIT] <= 1'b1;
        end else if (wr_hit && !wdata_q[`RSS_BOD_BIT]) begin
          cause_q[`RSS_BOD_BIT] <= 1'b0;
        end
        if (src.pin) begin
          cause_q[`RSS_PIN_BIT] <= 1'b1;
        end else if (wr_hit && !wdata_q[`RSS_PIN_BIT]) begin
          cause_q[`RSS_PIN_BIT] <= 1'b0;
        end
      end
      if (wr_hit) begin
        cause_q[`RSS_SLEEP_BIT] <= wdata_q[`RSS_SLEEP_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_select_top_bit_q <= 1'b0;
    end else begin
      sleep_select_top_bit_q <= cause_q[`RSS_SLEEP_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  AST_IO_ASYNC: assert property (@(posedge aclk) disable iff (!aresetn)
    async_src |-> io_reset_q)
    else $error("I/O reset not set while a pin or power source is active.");

  AST_WDT_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    wdt_expire && !wdt_enable |=> !wdt_pulse_q)
    else $error("Disabled watchdog produced a reset pulse.");

  AST_WDT_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
    wdt_pulse_q |=> !wdt_pulse_q)
    else $error("Watchdog reset pulse longer than one cycle.");

  AST_POR_IMM: assert property (@(posedge aclk) disable iff (!aresetn)
    por_detect |=> cpu_reset_q && state_q == RSS_ST_HOLD)
    else $error("Power-on source did not hold reset at once.");

  AST_STRETCH: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(any_src) |-> cpu_reset_q [*8])
    else $error("Reset released before the time-out.");

  AST_RUN_NEEDS_DONE: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(cpu_reset_q) |-> $past(stretch_done) && !$past(any_src))
    else $error("Reset released without a finished stretch.");

  AST_BOD_EN: assert property (@(posedge aclk) disable iff (!aresetn)
    !brownout_enable_fuse |-> !bod_trip)
    else $error("Brown-out tripped with its fuse unprogrammed.");

  AST_POR_FLAGS: assert property (@(posedge aclk) disable iff (!aresetn)
    por_detect |=> cause_q[`RSS_POR_BIT] && cause_q[3:1] == 3'h0)
    else $error("Power-on did not set its flag and clear the rest.");

  AST_POR_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
    cause_q[`RSS_POR_BIT] && !wr_clr_por |=> cause_q[`RSS_POR_BIT])
    else $error("Power-on flag lost without a clearing write.");

  AST_PIN_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    !ext_reset_n && !por_detect |=> cause_q[`RSS_PIN_BIT])
    else $error("Pin reset did not set its flag.");

  AST_RSVD_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0 && !s_axi_rdata[4])
    else $error("Unused cause bits read as one.");

endmodule : rss_top

//--- common/rss_consts.svh
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define RSS_ADDR_W 8
`define RSS_CAUSE_OFF 8'h00
`define RSS_CAUSE_W 8
`define RSS_CAUSE_RST 8'h00
`define RSS_POR_BIT 0
`define RSS_PIN_BIT 1
`define RSS_BOD_BIT 2
`define RSS_WDT_BIT 3
`define RSS_SLEEP_BIT 5
`define RSS_READ_MASK 8'h2F

// ----------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------
`define RSS_RESP_OKAY 2'h0
`define RSS_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RSS_CLK_MHZ 250
`define RSS_BOD_MIN_NS 2000
`define RSS_BOD_MIN_CYC ((`RSS_BOD_MIN_NS * `RSS_CLK_MHZ) / 1000)
`define RSS_PIN_MIN_NS 50
`define RSS_PIN_MIN_CYC ((`RSS_PIN_MIN_NS * `RSS_CLK_MHZ + 999) / 1000)
`define RSS_TOUT_BASE_CYC 4096
`define RSS_TOUT_SHIFT 2
`define RSS_RESET_VECTOR 16'h0000

`endif

//--- common/rss_pkg.sv
package rss_pkg;

  // --------------------------------------------------------------------
  // Sequencer states, Gray coded along hold, stretch, run.
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    RSS_ST_HOLD = 2'h0,
    RSS_ST_STRETCH = 2'h1,
    RSS_ST_RUN = 2'h3
  } rss_state_t;

  // --------------------------------------------------------------------
  // One indication per reset source.
  // --------------------------------------------------------------------
  typedef struct packed {
    logic wdt;
    logic bod;
    logic pin;
    logic por;
  } rss_src_t;

endpackage : rss_pkg

//--- logic/rss_bod_filter.sv
`timescale 1ns/1ns
`include "rss_consts.svh"

module rss_bod_filter #(
  parameter int MIN_CYC = `RSS_BOD_MIN_CYC,
  parameter int CNT_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic below,
  output logic trip_q
);
  import rss_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic active;

  initial begin
    if (MIN_CYC < 1 || MIN_CYC >= (1 << CNT_W)) begin
      $error("MIN_CYC does not fit the filter counter.");
    end
  end

  assign active = enable & below;

  // ----------------------------------------------------------------------
  // Dip length counter.
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !active) begin
      cnt_q <= '0;
    end else if (cnt_q != MIN_CYC[CNT_W-1:0]) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !active) begin
      trip_q <= 1'b0;
    end else if (cnt_q == MIN_CYC[CNT_W-1:0]) begin
      trip_q <= 1'b1;
    end
  end

  AST_BOD_SHORT: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(trip_q) |-> $past(active) && $past(cnt_q) == MIN_CYC[CNT_W-1:0])
    else $error("Brown-out trip without a long enough dip.");

endmodule : rss_bod_filter

//--- logic/rss_stretch.sv
`timescale 1ns/1ns
`include "rss_consts.svh"

module rss_stretch #(
  parameter int TOUT_BASE = `RSS_TOUT_BASE_CYC,
  parameter int CNT_W = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic restart,
  input wire logic [1:0] sel,
  output logic done_q
);
  import rss_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] target;

  initial begin
    if (TOUT_BASE < 8 ||
        (64'(TOUT_BASE) << (3 * `RSS_TOUT_SHIFT)) >= (64'h1 << CNT_W)) begin
      $error("TOUT_BASE does not fit the stretch counter.");
    end
  end

  function automatic logic [CNT_W-1:0] tout_cycles(input logic [1:0] s);
    tout_cycles = CNT_W'(TOUT_BASE) << (`RSS_TOUT_SHIFT * s);
  endfunction : tout_cycles

  assign target = tout_cycles(sel);

  // ----------------------------------------------------------------------
  // Time-out counter, restarted by any active source.
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (!done_q) begin
      if (cnt_q == target - 1'b1) begin
        done_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule : rss_stretch

//--- verification/rss_src_model.sv
`timescale 1ns/1ns
`include "rss_consts.svh"

module rss_src_model (
  input wire logic aclk,
  input wire rss_pkg::rss_src_t req,
  output logic por_detect,
  output logic ext_reset_n,
  output logic wdt_expire,
  output logic brownout_below
);
  import rss_pkg::*;
  int pin_cnt = 0;

  // --------------------------------------------------------------------
  // Power-on and pin move between sampling edges; watchdog and brown-out move on them.
  // --------------------------------------------------------------------
  initial begin
    por_detect = 1'b0;
    ext_reset_n = 1'b1;
    wdt_expire = 1'b0;
    brownout_below = 1'b0;
  end

  always @(negedge aclk) begin
    por_detect <= req.por;
    if (req.pin && ext_reset_n) begin
      pin_cnt <= `RSS_PIN_MIN_CYC;
    end else if (pin_cnt > 0) begin
      pin_cnt <= pin_cnt - 1;
    end
    ext_reset_n <= !(req.pin || pin_cnt > 0);
  end

  always @(posedge aclk) begin
    wdt_expire <= req.wdt;
    brownout_below <= req.bod;
  end
endmodule : rss_src_model

//--- verification/rss_top_tb.sv
`timescale 1ns/1ns
`include "rss_consts.svh"

module rss_top_tb;
  import rss_pkg::*;
  localparam int TB_BASE = 8;
  localparam logic [15:0] TB_VEC = 16'hA5C0;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic wdt_enable, brownout_enable_fuse, brownout_level_fuse;
  logic [1:0] clock_select_fuse;
  rss_src_t src;
  logic por_detect, ext_reset_n, wdt_expire, brownout_below;
  logic cpu_reset_q, io_reset_q, vector_load_q, bod_level_high_q;
  logic sleep_select_top_bit_q;
  logic [15:0] reset_vector_q;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int error_cnt = 0;
  int samples_checked = 0;
  int seed = 20;
  logic [7:0] exp_cause;

  always #2 aclk = ~aclk;

  rss_src_model rss_src_model_i (.aclk, .req(src), .por_detect,
    .ext_reset_n, .wdt_expire, .brownout_below);

  rss_top #(.TOUT_BASE(TB_BASE), .BOD_MIN_CYC(4), .RESET_VECTOR(TB_VEC))
  rss_top_i (.aclk, .aresetn, .por_detect, .ext_reset_n, .wdt_expire,
    .wdt_enable, .brownout_below, .brownout_enable_fuse,
    .brownout_level_fuse, .clock_select_fuse, .cpu_reset_q, .io_reset_q,
    .vector_load_q, .reset_vector_q, .bod_level_high_q,
    .sleep_select_top_bit_q, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // --------------------------------------------------------------------
  // Expectations, comparisons and bus cycles.
  // --------------------------------------------------------------------
  function automatic int tout(input logic [1:0] s);
    return TB_BASE << (2 * s);
  endfunction : tout

  function automatic logic [7:0] cause_next(input logic [7:0] c,
                                            input rss_src_t s);
    if (s.por) return (c & 8'h21) | 8'h01;
    return c | {4'h0, s.wdt, s.bod, s.pin, 1'b0};
  endfunction : cause_next

  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_cyc(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("[ERR] %0t cycles %h range %h %h", $time, got, lo, hi);
    end
  endtask : chk_cyc

  task automatic hang;
    error_cnt++;
    complete_run();
  endtask : hang

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    if (n >= 200) hang();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n >= 200) hang();
  endtask : rd

  // Applies one source; unless cut is set, then measures the stretch and reads the flags.
  task automatic shot(input rss_src_t s, input int hold, input logic hit,
                      input int cut);
    int n, last, vl, lo;
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    last = 0;
    vl = 0;
    if (hit) exp_cause = cause_next(exp_cause, s);
    @(posedge aclk);
    src <= s;
    @(negedge aclk);
    #1;
    if (s.por || s.pin) chk(io_reset_q, 1);
    repeat (hold) @(posedge aclk);
    src <= '0;
    if (cut > 0) begin
      repeat (cut) @(posedge aclk);
      return;
    end
    while (n < 3000 && (n < 6 || n < last + 4)) begin
      @(posedge aclk);
      #1;
      n++;
      if (cpu_reset_q) last = n;
      if (vector_load_q) vl++;
    end
    if (n >= 3000) hang();
    chk(last > 0, hit);
    // A watchdog stretch runs from its one-cycle pulse, not from the hold.
    lo = tout(clock_select_fuse);
    if (s.wdt) lo = lo + 3 - hold;
    else if (s.bod) lo = lo + 2;
    else if (s == '0) lo = lo - 1;
    if (hit) chk_cyc(last, lo, lo + 8);
    chk(vl, hit);
    chk(reset_vector_q, TB_VEC);
    chk(bod_level_high_q, brownout_level_fuse);
    rd(`RSS_CAUSE_OFF, d, r);
    chk(d, exp_cause);
  endtask : shot

  initial begin
    #400000;
    hang();
  end

  // --------------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------------
  initial begin
    rss_src_t list [5];
    logic [31:0] d, q;
    logic [1:0] r;
    list = '{4'b0010, 4'b1000, 4'b0100, 4'b0001, 4'b0010};
    src = '0;
    wdt_enable = 1'b1;
    brownout_enable_fuse = 1'b1;
    brownout_level_fuse = 1'b0;
    clock_select_fuse = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    exp_cause = 8'h00;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    shot('0, 0, 1'b1, 0);
    for (int k = 0; k < 5; k++) begin
      clock_select_fuse <= 2'(k);
      brownout_level_fuse <= 1'($random(seed));
      shot(list[k], 16, 1'b1, 0);
    end
    for (int k = 0; k < 4; k++) begin
      d = $random(seed);
      wr(`RSS_CAUSE_OFF, d, r);
      exp_cause = (exp_cause & d[7:0] & 8'h0F) | (d[7:0] & 8'h20);
      rd(`RSS_CAUSE_OFF, q, r);
      chk(q, exp_cause);
      chk(sleep_select_top_bit_q, exp_cause[5]);
    end
    wr(`RSS_CAUSE_OFF, 32'h0, r);
    exp_cause = 8'h00;
    wdt_enable <= 1'b0;
    shot(4'b1000, 1, 1'b0, 0);
    wdt_enable <= 1'b1;
    shot(4'b0100, 3, 1'b0, 0);
    brownout_enable_fuse <= 1'b0;
    shot(4'b0100, 16, 1'b0, 0);
    brownout_enable_fuse <= 1'b1;
    shot(4'b0010, 16, 1'b1, 5);
    shot(4'b0010, 16, 1'b1, 0);
    wr(8'h04, 32'hFF, r);
    chk(r, `RSS_RESP_SLVERR);
    rd(8'h04, q, r);
    chk(q, 32'h0);
    chk(r, `RSS_RESP_SLVERR);
    rd(`RSS_CAUSE_OFF, q, r);
    chk(q, exp_cause);
    complete_run();
  end
endmodule : rss_top_tb
